// ==== tcel_defines.svh ====
`ifndef TCEL_DEFINES_SVH
`define TCEL_DEFINES_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TCEL_CTRLB_CLR_OFS 8'h04
`define TCEL_CTRLB_SET_OFS 8'h05
`define TCEL_CTRLC_OFS 8'h06
`define TCEL_EVENT_CONTROL_REG_OFS 8'h07
`define TCEL_INTEN_CLR_OFS 8'h0c
`define TCEL_INTEN_SET_OFS 8'h0d
`define TCEL_IRQ_FLAG_REG_OFS 8'h0e
`define TCEL_STATUS_OFS 8'h0f
`define TCEL_COUNT_OFS 8'h10
`define TCEL_PER_OFS 8'h14
`define TCEL_CC0_OFS 8'h18
`define TCEL_CC1_OFS 8'h1c
`define TCEL_CMD_OFS 8'h20
// ----------------------------------------
// field positions
// ----------------------------------------
`define TCEL_CTRLB_DIR_BIT 0
`define TCEL_CTRLB_SINGLE_RUN_BIT_BIT 2
`define TCEL_CTRLC_CAPTURE_CHANNEL_ENABLE_LSB 4
`define TCEL_EV_ACT_LSB 0
`define TCEL_EV_INV_BIT 4
`define TCEL_EV_EVENT_INPUT_ENABLE_BIT 5
`define TCEL_EV_OVFEO_BIT 8
`define TCEL_EV_MCEO_LSB 12
`define TCEL_IF_OVF_BIT 0
`define TCEL_IF_ERR_BIT 1
`define TCEL_IF_SYNC_BIT 3
`define TCEL_IF_MC_LSB 4
`define TCEL_ST_STOP_BIT 3
`define TCEL_CMD_RETRIG_BIT 0
`define TCEL_CMD_SYNC_BIT 1
// ----------------------------------------
// reset values
// ----------------------------------------
`define TCEL_COUNT_RST 16'h0000
`define TCEL_PER_RST 16'hffff
`define TCEL_FLAGS_RST 8'h00
`endif

// ==== tcel_pkg.sv ====
package tcel_pkg;
  typedef enum logic [2:0] {
    TCEL_EV_OFF,
    TCEL_EV_RETRIGGER,
    TCEL_EV_COUNT,
    TCEL_EV_START,
    TCEL_EV_PPW,
    TCEL_EV_PWP,
    TCEL_EV_RSVD6,
    TCEL_EV_RSVD7
  } tcel_event_action_select_e;
  typedef logic [15:0] tcel_cnt_t;
endpackage

// ==== tcel_timer_capture_event_logic.sv ====
`timescale 1ns/1ps
`include "tcel_defines.svh"
module tcel_timer_capture_event_logic
  import tcel_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic EV_IN,
  input wire logic [1:0] PIN_CAPT,
  output logic [1:0] WAVEFORM_OUTPUT,
  output logic DMA_OVF_REQ,
  output logic [1:0] DMA_MC_REQ,
  output logic IRQ,
  output logic EV_OVF_OUT,
  output logic [1:0] EV_MC_OUT
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic dir_r;
  logic single_run_bit_r;
  logic [1:0] capture_channel_enable_r;
  logic [15:0] event_control_reg_r;
  logic [7:0] irq_en_r;
  logic [7:0] irq_flag_reg_r;
  logic stop_r;
  tcel_cnt_t count_r;
  tcel_cnt_t per_r;
  tcel_cnt_t per_buf_r;
  tcel_cnt_t cc_r [2];
  tcel_cnt_t cc_buf_r [2];
  logic [1:0] cc_buf_v_r;
  logic per_buf_v_r;
  logic ev_in_d_r;
  logic [1:0] wo_r;
  logic dma_ovf_r;
  logic [1:0] dma_mc_r;
  logic ev_ovf_r;
  logic [1:0] ev_mc_r;
  logic sync_rdy_r;
  logic [31:0] prdata_r;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  tcel_event_action_select_e event_action_select;
  logic wr, rd, ev_en, inv, two_edge, ev_lvl, ev_rise, ev_fall, restart_edge;
  logic fab_ev, retrig_cmd, ovf, start_cond, count_step;
  logic [1:0] cap_ev, cap_ok, cap_err, cmp_match, cc_read;
  logic [7:0] wmask;
  assign wr = PSEL && PENABLE && PWRITE;
  assign rd = PSEL && PENABLE && !PWRITE;
  assign PREADY = 1'b1;
  assign PSLVERR = 1'b0;
  assign PRDATA = prdata_r;
  assign event_action_select = tcel_event_action_select_e'(event_control_reg_r[`TCEL_EV_ACT_LSB +: 3]);
  assign ev_en = event_control_reg_r[`TCEL_EV_EVENT_INPUT_ENABLE_BIT];
  assign inv = event_control_reg_r[`TCEL_EV_INV_BIT];
  assign two_edge = (event_action_select == TCEL_EV_PPW) || (event_action_select == TCEL_EV_PWP);
  assign ev_lvl = EV_IN && ev_en;
  assign ev_rise = ev_lvl && !ev_in_d_r;
  assign ev_fall = !ev_lvl && ev_in_d_r && ev_en;
  // invert picks which edge restarts the counter
  assign restart_edge = inv ? ev_fall : ev_rise;
  assign fab_ev = ev_rise && !two_edge;
  assign retrig_cmd = wr && PADDR == `TCEL_CMD_OFS && PWDATA[`TCEL_CMD_RETRIG_BIT];
  assign count_step = (event_action_select == TCEL_EV_COUNT) ? fab_ev : 1'b1;
  assign ovf = !stop_r && count_step &&
               (dir_r ? (count_r == 16'h0000) : (count_r == per_r));
  assign start_cond = retrig_cmd ||
                      (fab_ev && (event_action_select == TCEL_EV_RETRIGGER || event_action_select == TCEL_EV_START));
  assign wmask = PWDATA[7:0];

  // ----------------------------------------
  // per-channel capture and compare
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      logic te;
      // period lands where restart edge is; width on the opposite edge
      assign te = ((event_action_select == TCEL_EV_PWP) == (g == 1)) ? restart_edge
                                                      : ((ev_rise || ev_fall) && !restart_edge);
      assign cap_ev[g] = capture_channel_enable_r[g] &&
                         (two_edge ? te : (ev_rise || (PIN_CAPT[g] && ev_en)));
      assign cap_err[g] = cap_ev[g] && irq_flag_reg_r[`TCEL_IF_MC_LSB + g];
      assign cap_ok[g] = cap_ev[g] && !irq_flag_reg_r[`TCEL_IF_MC_LSB + g];
      assign cmp_match[g] = !capture_channel_enable_r[g] && !stop_r && count_r == cc_r[g];
      assign cc_read[g] = rd && PADDR == (`TCEL_CC0_OFS + 8'(4 * g));
      always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
          cc_r[g] <= `TCEL_COUNT_RST;
          cc_buf_r[g] <= `TCEL_COUNT_RST;
          cc_buf_v_r[g] <= 1'b0;
        end else begin
          if (cap_ok[g]) begin
            cc_r[g] <= count_r;
          end else if (ovf && cc_buf_v_r[g]) begin
            cc_r[g] <= cc_buf_r[g];
          end
          if (wr && PADDR == (`TCEL_CC0_OFS + 8'(4 * g))) begin
            cc_buf_r[g] <= PWDATA[15:0];
            cc_buf_v_r[g] <= 1'b1;
          end else if (ovf) begin
            cc_buf_v_r[g] <= 1'b0;
          end
        end
      end
      always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
          dma_mc_r[g] <= 1'b0;
        end else if (capture_channel_enable_r[g]) begin
          // held until value is read; new data wins over the read
          dma_mc_r[g] <= cap_ok[g] || (dma_mc_r[g] && !cc_read[g]);
        end else begin
          dma_mc_r[g] <= cmp_match[g];
        end
      end
      always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
          ev_mc_r[g] <= 1'b0;
          wo_r[g] <= 1'b0;
        end else begin
          ev_mc_r[g] <= (cap_ok[g] || cmp_match[g]) &&
                        event_control_reg_r[`TCEL_EV_MCEO_LSB + g];
          if (ovf && single_run_bit_r) begin
            wo_r[g] <= 1'b0;
          end else if (cmp_match[g]) begin
            wo_r[g] <= !wo_r[g];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // counter and single run
  // ----------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      count_r <= `TCEL_COUNT_RST;
      per_r <= `TCEL_PER_RST;
      per_buf_r <= `TCEL_PER_RST;
      per_buf_v_r <= 1'b0;
      ev_in_d_r <= 1'b0;
    end else begin
      ev_in_d_r <= ev_lvl;
      if (wr && PADDR == `TCEL_COUNT_OFS) begin
        count_r <= PWDATA[15:0];
      end else if (two_edge && restart_edge) begin
        count_r <= dir_r ? per_r : 16'h0000;
      end else if (start_cond && !stop_r && event_action_select != TCEL_EV_START) begin
        count_r <= dir_r ? per_r : 16'h0000;
      end else if (ovf) begin
        count_r <= dir_r ? (per_buf_v_r ? per_buf_r : per_r) : 16'h0000;
      end else if (!stop_r && count_step) begin
        count_r <= dir_r ? count_r - 16'h0001 : count_r + 16'h0001;
      end
      if (ovf && per_buf_v_r) begin
        per_r <= per_buf_r;
      end
      if (wr && PADDR == `TCEL_PER_OFS) begin
        per_buf_r <= PWDATA[15:0];
        per_buf_v_r <= 1'b1;
      end else if (ovf) begin
        per_buf_v_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      dir_r <= 1'b0;
      single_run_bit_r <= 1'b0;
      stop_r <= 1'b0;
    end else begin
      if (wr && PADDR == `TCEL_CTRLB_SET_OFS) begin
        dir_r <= dir_r | PWDATA[`TCEL_CTRLB_DIR_BIT];
        single_run_bit_r <= single_run_bit_r | PWDATA[`TCEL_CTRLB_SINGLE_RUN_BIT_BIT];
      end else if (wr && PADDR == `TCEL_CTRLB_CLR_OFS) begin
        dir_r <= dir_r & !PWDATA[`TCEL_CTRLB_DIR_BIT];
        single_run_bit_r <= single_run_bit_r & !PWDATA[`TCEL_CTRLB_SINGLE_RUN_BIT_BIT];
      end
      if (start_cond) begin
        stop_r <= 1'b0;
      end else if (ovf && single_run_bit_r) begin
        stop_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // control, flags and enables
  // ----------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      capture_channel_enable_r <= 2'b00;
      event_control_reg_r <= 16'h0000;
      sync_rdy_r <= 1'b0;
    end else begin
      if (wr && PADDR == `TCEL_CTRLC_OFS) begin
        capture_channel_enable_r <= PWDATA[`TCEL_CTRLC_CAPTURE_CHANNEL_ENABLE_LSB +: 2];
      end
      if (wr && PADDR == `TCEL_EVENT_CONTROL_REG_OFS) begin
        event_control_reg_r <= PWDATA[15:0];
      end
      sync_rdy_r <= wr && PADDR == `TCEL_CMD_OFS && PWDATA[`TCEL_CMD_SYNC_BIT];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      irq_en_r <= `TCEL_FLAGS_RST;
    end else if (wr && PADDR == `TCEL_INTEN_SET_OFS) begin
      irq_en_r <= irq_en_r | wmask;
    end else if (wr && PADDR == `TCEL_INTEN_CLR_OFS) begin
      irq_en_r <= irq_en_r & ~wmask;
    end
  end

  logic [7:0] set_v, clr_v;
  always_comb begin
    set_v = 8'h00;
    set_v[`TCEL_IF_OVF_BIT] = ovf;
    set_v[`TCEL_IF_ERR_BIT] = |cap_err;
    set_v[`TCEL_IF_SYNC_BIT] = sync_rdy_r;
    set_v[`TCEL_IF_MC_LSB +: 2] = cap_ok | cmp_match;
    clr_v = (wr && PADDR == `TCEL_IRQ_FLAG_REG_OFS) ? wmask : 8'h00;
    // reading a channel value also clears its flag so the next capture lands
    clr_v[`TCEL_IF_MC_LSB +: 2] = clr_v[`TCEL_IF_MC_LSB +: 2] | cc_read;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      irq_flag_reg_r <= `TCEL_FLAGS_RST;
    end else begin
      irq_flag_reg_r <= (irq_flag_reg_r & ~clr_v) | set_v;
    end
  end

  assign IRQ = |(irq_flag_reg_r & irq_en_r);

  // ----------------------------------------
  // requests and events
  // ----------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      dma_ovf_r <= 1'b0;
      ev_ovf_r <= 1'b0;
    end else begin
      dma_ovf_r <= ovf;
      ev_ovf_r <= ovf && event_control_reg_r[`TCEL_EV_OVFEO_BIT];
    end
  end
  assign DMA_OVF_REQ = dma_ovf_r;
  assign DMA_MC_REQ = dma_mc_r;
  assign EV_OVF_OUT = ev_ovf_r;
  assign EV_MC_OUT = ev_mc_r;
  assign WAVEFORM_OUTPUT = wo_r;

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      prdata_r <= 32'h00000000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      unique case (PADDR)
        `TCEL_CTRLB_SET_OFS, `TCEL_CTRLB_CLR_OFS: prdata_r <=
          32'(single_run_bit_r) << `TCEL_CTRLB_SINGLE_RUN_BIT_BIT | 32'(dir_r);
        `TCEL_CTRLC_OFS: prdata_r <= 32'(capture_channel_enable_r) << `TCEL_CTRLC_CAPTURE_CHANNEL_ENABLE_LSB;
        `TCEL_EVENT_CONTROL_REG_OFS: prdata_r <= 32'(event_control_reg_r);
        `TCEL_INTEN_SET_OFS, `TCEL_INTEN_CLR_OFS: prdata_r <= 32'(irq_en_r);
        `TCEL_IRQ_FLAG_REG_OFS: prdata_r <= 32'(irq_flag_reg_r);
        `TCEL_STATUS_OFS: prdata_r <= 32'(stop_r) << `TCEL_ST_STOP_BIT;
        `TCEL_COUNT_OFS: prdata_r <= 32'(count_r);
        `TCEL_PER_OFS: prdata_r <= 32'(per_r);
        `TCEL_CC0_OFS: prdata_r <= 32'(cc_r[0]);
        `TCEL_CC1_OFS: prdata_r <= 32'(cc_r[1]);
        default: prdata_r <= 32'h00000000;
      endcase
    end
  end
endmodule

// ==== tcel_checker.sv ====
`timescale 1ns/1ps
`include "tcel_defines.svh"
module tcel_checker (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input logic PREADY,
  input logic PSLVERR,
  input logic DMA_OVF_REQ,
  input logic [1:0] DMA_MC_REQ,
  input logic IRQ,
  input logic EV_OVF_OUT,
  input logic [1:0] EV_MC_OUT
);
  // ----------------------------------------
  // port relations
  // ----------------------------------------
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  ovf_dma_pulse_a: assert property (DMA_OVF_REQ |=> !DMA_OVF_REQ)
    else $error("overflow dma request too long");
  ovf_ev_dma_a: assert property (EV_OVF_OUT |-> DMA_OVF_REQ)
    else $error("overflow event without dma request");
  ev_mc_pulse_a: assert property (EV_MC_OUT != 2'b00 |=>
    (EV_MC_OUT & $past(EV_MC_OUT)) == 2'b00) else $error("match event too long");
  // a level that dies for any other cause than a read of its channel value or a write means lost data
  cap_hold0_a: assert property ((DMA_MC_REQ[0] && $past(DMA_MC_REQ[0])) ##1
    !DMA_MC_REQ[0] |-> $past(PSEL && (PWRITE || PADDR == `TCEL_CC0_OFS)))
    else $error("ch0 request dropped unread");
  cap_hold1_a: assert property ((DMA_MC_REQ[1] && $past(DMA_MC_REQ[1])) ##1
    !DMA_MC_REQ[1] |-> $past(PSEL && (PWRITE || PADDR == `TCEL_CC1_OFS)))
    else $error("ch1 request dropped unread");
  irq_drop_a: assert property ($fell(IRQ) |->
    $past(PSEL && (PWRITE || PADDR[7:4] == 4'h1))) else $error("irq fell without access");
  reset_quiet_a: assert property (disable iff (1'b0) !RST_N |=>
    !IRQ && !DMA_OVF_REQ && DMA_MC_REQ == 2'b00) else $error("outputs busy after reset");
  apb_ready_a: assert property (PREADY && !PSLVERR)
    else $error("apb answer not ready or error");
  cover property (DMA_OVF_REQ && EV_OVF_OUT);
  cover property (DMA_MC_REQ[1] [*2]);
  cover property ($fell(IRQ));
endmodule
bind tcel_timer_capture_event_logic tcel_checker u_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
  .PSEL(PSEL), .PWRITE(PWRITE), .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .DMA_OVF_REQ(DMA_OVF_REQ), .DMA_MC_REQ(DMA_MC_REQ), .IRQ(IRQ),
  .EV_OVF_OUT(EV_OVF_OUT), .EV_MC_OUT(EV_MC_OUT));

// ==== tcel_ev_src.sv ====
`timescale 1ns/1ps
module tcel_ev_src (
  input wire logic clk,
  input wire logic run,
  input wire logic [7:0] high_len,
  input wire logic [7:0] per_len,
  output logic ev
);
  // ----------------------------------------
  // fabric event line
  // ----------------------------------------
  logic [7:0] cnt_r;
  // raw level straight onto the path, no resync on this side
  always_ff @(posedge clk) begin
    if (!run) begin
      cnt_r <= 8'h00;
      ev <= 1'b0;
    end else begin
      cnt_r <= (cnt_r + 8'h01 >= per_len) ? 8'h00 : cnt_r + 8'h01;
      ev <= cnt_r < high_len;
    end
  end
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
`include "tcel_defines.svh"
module tb_top;
  logic CLK_SYS = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00, hi_len = 8'h04, per_len = 8'h0a;
  logic [31:0] PWDATA = 32'h0, PRDATA;
  logic [1:0] PIN_CAPT = 2'b00, WAVEFORM_OUTPUT, DMA_MC_REQ, EV_MC_OUT;
  logic run = 1'b0, PREADY, PSLVERR, EV_IN, DMA_OVF_REQ, IRQ, EV_OVF_OUT;
  logic [31:0] exp_q[$], msk_q[$];
  int n_mismatch = 0, num_checks = 0, seed = 32'h0674, h, t, pw, i;
  always #20 CLK_SYS = ~CLK_SYS;
  tcel_timer_capture_event_logic u_dut (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .EV_IN(EV_IN), .PIN_CAPT(PIN_CAPT),
    .WAVEFORM_OUTPUT(WAVEFORM_OUTPUT), .DMA_OVF_REQ(DMA_OVF_REQ), .DMA_MC_REQ(DMA_MC_REQ),
    .IRQ(IRQ), .EV_OVF_OUT(EV_OVF_OUT), .EV_MC_OUT(EV_MC_OUT));
  tcel_ev_src u_src (.clk(CLK_SYS), .run(run), .high_len(hi_len), .per_len(per_len),
    .ev(EV_IN));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask
  // one idle cycle after each transfer keeps drivers from double assignment
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    cyc(1);
    PENABLE <= 1'b1;
    do cyc(1); while (PREADY !== 1'b1);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    cyc(1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    exp_q.push_back(e);
    msk_q.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic pin(input logic [1:0] v);
    PIN_CAPT <= v;
    cyc(1);
    PIN_CAPT <= 2'b00;
    cyc(2);
  endtask
  // sample on the falling edge, where the one-cycle pulses have settled
  task automatic wait_ovf(input logic e);
    int k;
    k = 0;
    do begin
      @(negedge CLK_SYS);
      k++;
    end while (k < 100 && DMA_OVF_REQ !== 1'b1);
    chk("ovf dma", DMA_OVF_REQ, 1'b1);
    chk("ovf event", EV_OVF_OUT, e);
    @(posedge CLK_SYS);
  endtask
  task automatic end_sim;
    if (n_mismatch == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge CLK_SYS)
    if (PSEL && PENABLE && !PWRITE && PREADY && exp_q.size() > 0)
      chk("read data", PRDATA & msk_q.pop_front(), exp_q.pop_front());
  initial begin
    #(40 * 20000);
    n_mismatch++;
    end_sim();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    cyc(3);
    RST_N <= 1'b1;
    cyc(1);
    // counter and compare values both start at zero, so match flags may be up
    rd(`TCEL_IRQ_FLAG_REG_OFS, 32'h0f, 32'h0);
    rd(8'h30, 32'hffffffff, 32'h0);
    wr(`TCEL_CTRLC_OFS, 32'h30);
    wr(`TCEL_IRQ_FLAG_REG_OFS, 32'hff);
    pin(2'b11);
    rd(`TCEL_IRQ_FLAG_REG_OFS, 32'h32, 32'h0);
    for (i = 0; i < 4; i++) begin
      wr(`TCEL_EVENT_CONTROL_REG_OFS, 32'h3120 | i);
      wr(`TCEL_IRQ_FLAG_REG_OFS, 32'hff);
      pin(2'b01);
      rd(`TCEL_IRQ_FLAG_REG_OFS, 32'h10, 32'h10);
      chk("mc dma", DMA_MC_REQ, 2'b01);
    end
    pin(2'b01);
    pin(2'b10);
    rd(`TCEL_IRQ_FLAG_REG_OFS, 32'h32, 32'h32);
    wr(`TCEL_INTEN_SET_OFS, 32'h02);
    chk("irq", IRQ, 1'b1);
    wr(`TCEL_INTEN_CLR_OFS, 32'h02);
    chk("irq", IRQ, 1'b0);
    wr(`TCEL_INTEN_SET_OFS, 32'h0a);
    wr(`TCEL_IRQ_FLAG_REG_OFS, 32'h02);
    chk("irq", IRQ, 1'b0);
    wr(`TCEL_CMD_OFS, 32'h02);
    rd(`TCEL_IRQ_FLAG_REG_OFS, 32'h0b, 32'h08);
    chk("irq", IRQ, 1'b1);
    wr(`TCEL_INTEN_CLR_OFS, 32'hff);
    for (i = 0; i < 4; i++) begin
      h = 3 + ($random(seed) & 7);
      t = h + 3 + ($random(seed) & 7);
      hi_len <= 8'(h);
      per_len <= 8'(t);
      wr(`TCEL_EVENT_CONTROL_REG_OFS, 32'h3124 | (i & 1) | ((i & 2) << 3));
      run <= 1'b1;
      cyc(2 * t);
      wr(`TCEL_IRQ_FLAG_REG_OFS, 32'hff);
      cyc(2 * t);
      run <= 1'b0;
      // timestamp is the count seen at the edge, one below the cycle span
      pw = ((i & 2) ? t - h : h) - 1;
      t = t - 1;
      rd(`TCEL_CC0_OFS, 32'hffff, (i & 1) ? pw : t);
      rd(`TCEL_CC1_OFS, 32'hffff, (i & 1) ? t : pw);
    end
    wr(`TCEL_EVENT_CONTROL_REG_OFS, 32'h3123);
    wr(`TCEL_CTRLB_SET_OFS, 32'h04);
    wr(`TCEL_COUNT_OFS, 32'hfff0);
    wait_ovf(1'b1);
    rd(`TCEL_STATUS_OFS, 32'h08, 32'h08);
    chk("waveform", WAVEFORM_OUTPUT, 2'b00);
    pin(2'b01);
    rd(`TCEL_STATUS_OFS, 32'h08, 32'h08);
    run <= 1'b1;
    cyc(3);
    run <= 1'b0;
    cyc(2);
    rd(`TCEL_STATUS_OFS, 32'h08, 32'h00);
    wr(`TCEL_COUNT_OFS, 32'hfff0);
    wait_ovf(1'b1);
    wr(`TCEL_CMD_OFS, 32'h01);
    rd(`TCEL_STATUS_OFS, 32'h08, 32'h00);
    wr(`TCEL_CTRLB_CLR_OFS, 32'h04);
    wr(`TCEL_EVENT_CONTROL_REG_OFS, 32'h20);
    wr(`TCEL_COUNT_OFS, 32'hfff0);
    wait_ovf(1'b0);
    rd(`TCEL_STATUS_OFS, 32'h08, 32'h00);
    rd(`TCEL_IRQ_FLAG_REG_OFS, 32'h01, 32'h01);
    end_sim();
  end
endmodule
